/* File: verilog/dmx_pkg.sv */
package dmx_pkg;

    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROC, PH_WRITE} dmx_phase_t;

    typedef enum logic [3:0] {
        OP_NONE, OP_PTR_HI, OP_PTR_LO, OP_FMOVE, OP_MM_SRC,
        OP_MM_DST, OP_BANK, OP_LIT, OP_STORE
    } dmx_op_t;

    typedef enum logic [1:0] {PEND_NONE, PEND_PTR, PEND_MOVE} dmx_pend_t;

    // Opcode prefixes, compared against the top bits of a word
    localparam logic [9:0] PTR_PFX    = 10'h3B8;
    localparam logic [7:0] PTR2_PFX   = 8'hF0;
    localparam logic [5:0] FMOVE_PFX  = 6'h14;
    localparam logic [3:0] MM_PFX     = 4'hC;
    localparam logic [3:0] SECOND_PFX = 4'hF;
    localparam logic [7:0] BANK_PFX   = 8'h01;
    localparam logic [7:0] LIT_PFX    = 8'h0E;
    localparam logic [6:0] STORE_PFX  = 7'h37;

    // Field positions
    localparam int PTR_SEL_LSB = 4;
    localparam int DEST_BIT    = 9;
    localparam int ACCESS_BIT  = 8;

    // Addressing
    localparam logic [7:0]  IDX_LIMIT    = 8'h5F;
    localparam logic [3:0]  LO_PAGE      = 4'h0;
    localparam logic [3:0]  HI_PAGE      = 4'hF;
    localparam logic [7:0]  BANK_MASK    = 8'h0F;
    localparam logic [1:0]  IDX_PTR      = 2'h2;
    localparam logic [1:0]  PTR_COUNT    = 2'h3;
    // Data address at which the working register is mapped
    localparam logic [11:0] ACC_ADDR     = 12'hFE8;

    // Values after reset
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [11:0] RST_PTR      = 12'h000;
    localparam logic [11:0] RST_ADDR     = 12'h000;

endpackage

/* File: verilog/dmx_exec.sv */
`timescale 1ns/10ps

// What this block does
// - Two-word pointer load writes 12-bit literal into selected pointer over two cycles
// - File move copies f to working register or back to f, sets N and Z
// - Destination bit zero sends file-move result to the working register
// - Access bit zero uses access bank; one forms address from bank select plus f
// - Access bit zero with extended set uses indexed offset for f up to 5Fh
// - Eight-bit file field reaches any byte of the selected 256-byte bank
// - Two-word memory move copies source byte to destination, no flag change
// - Memory move source and destination span the whole 000h to FFFh space
// - Working register may be source or destination of the memory move
// - Bank-select load writes literal low nibble; upper nibble stays zero, flags kept
// - Literal load puts 8-bit literal in working register in one cycle
// - Store copies working register into addressed file register, flags kept
// - Fixed-bank select uses access bank, banked mode uses bank select register
module dmx_exec (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              instr_valid,
    input  wire logic [15:0]       instr_word,
    input  wire logic              ext_set_en,
    input  wire logic [7:0]        dmem_rdata,
    output dmx_pkg::dmx_phase_t    phase_q,
    output logic                   second_word_q,
    output logic      [7:0]        acc_q,
    output logic      [7:0]        bank_sel_q,
    output logic      [11:0]       ptr0_q,
    output logic      [11:0]       ptr1_q,
    output logic      [11:0]       ptr2_q,
    output logic                   flag_n_q,
    output logic                   flag_z_q,
    output logic      [11:0]       dmem_addr_q,
    output logic                   dmem_rd_q,
    output logic                   dmem_wr_q,
    output logic      [7:0]        dmem_wdata_q
);

    dmx_pkg::dmx_op_t   op_q;
    dmx_pkg::dmx_op_t   op_d;
    dmx_pkg::dmx_pend_t pend_q;
    dmx_pkg::dmx_pend_t pend_d;
    logic [11:0]        addr_d;
    logic [7:0]         lit_q;
    logic [7:0]         lit_d;
    logic [1:0]         sel_q;
    logic [1:0]         sel_d;
    logic               dst_f_q;
    logic               dst_f_d;
    logic [7:0]         mm_q;
    logic [7:0]         rd_val;
    logic               at_decode;
    logic               at_proc;
    logic               to_acc;

    assign at_decode = (phase_q == dmx_pkg::PH_DECODE);
    assign at_proc   = (phase_q == dmx_pkg::PH_PROC);

    ////////////////////////////////////////////////////////////////////////////////
    // Address forming for single-word file operations

    function automatic logic [11:0] file_addr(input logic [7:0]  f,
                                              input logic        a,
                                              input logic        ext,
                                              input logic [7:0]  bank,
                                              input logic [11:0] idx);
        if (a) begin
            file_addr = {bank[3:0], f};
        end else if (ext && f <= dmx_pkg::IDX_LIMIT) begin
            file_addr = idx + {4'h0, f};
        end else if (f <= dmx_pkg::IDX_LIMIT) begin
            file_addr = {dmx_pkg::LO_PAGE, f};
        end else begin
            file_addr = {dmx_pkg::HI_PAGE, f};
        end
    endfunction

    // Working register is mapped in data space, so reads of it bypass memory
    function automatic logic is_acc(input logic [11:0] addr);
        is_acc = (addr == dmx_pkg::ACC_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Phase sequencer

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= dmx_pkg::PH_DECODE;
        end else begin
            case (phase_q)
                dmx_pkg::PH_DECODE: phase_q <= dmx_pkg::PH_READ;
                dmx_pkg::PH_READ:   phase_q <= dmx_pkg::PH_PROC;
                dmx_pkg::PH_PROC:   phase_q <= dmx_pkg::PH_WRITE;
                default:            phase_q <= dmx_pkg::PH_DECODE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    always_comb begin
        op_d    = dmx_pkg::OP_NONE;
        pend_d  = dmx_pkg::PEND_NONE;
        addr_d  = dmem_addr_q;
        lit_d   = lit_q;
        sel_d   = sel_q;
        dst_f_d = dst_f_q;
        if (pend_q == dmx_pkg::PEND_PTR) begin
            // A malformed second word drops the low-byte write
            if (instr_valid && instr_word[15:8] == dmx_pkg::PTR2_PFX) begin
                op_d  = dmx_pkg::OP_PTR_LO;
                lit_d = instr_word[7:0];
            end
        end else if (pend_q == dmx_pkg::PEND_MOVE) begin
            if (instr_valid && instr_word[15:12] == dmx_pkg::SECOND_PFX) begin
                op_d   = dmx_pkg::OP_MM_DST;
                addr_d = instr_word[11:0];
            end
        end else if (!instr_valid) begin
            op_d = dmx_pkg::OP_NONE;
        end else if (instr_word[15:6] == dmx_pkg::PTR_PFX) begin
            op_d   = dmx_pkg::OP_PTR_HI;
            pend_d = dmx_pkg::PEND_PTR;
            sel_d  = instr_word[dmx_pkg::PTR_SEL_LSB +: 2];
            lit_d  = {4'h0, instr_word[3:0]};
        end else if (instr_word[15:12] == dmx_pkg::MM_PFX) begin
            op_d   = dmx_pkg::OP_MM_SRC;
            pend_d = dmx_pkg::PEND_MOVE;
            addr_d = instr_word[11:0];
        end else if (instr_word[15:10] == dmx_pkg::FMOVE_PFX) begin
            op_d    = dmx_pkg::OP_FMOVE;
            dst_f_d = instr_word[dmx_pkg::DEST_BIT];
            addr_d  = file_addr(instr_word[7:0], instr_word[dmx_pkg::ACCESS_BIT],
                                ext_set_en, bank_sel_q, ptr2_q);
        end else if (instr_word[15:8] == dmx_pkg::BANK_PFX) begin
            op_d  = dmx_pkg::OP_BANK;
            lit_d = instr_word[7:0];
        end else if (instr_word[15:8] == dmx_pkg::LIT_PFX) begin
            op_d  = dmx_pkg::OP_LIT;
            lit_d = instr_word[7:0];
        end else if (instr_word[15:9] == dmx_pkg::STORE_PFX) begin
            op_d   = dmx_pkg::OP_STORE;
            addr_d = file_addr(instr_word[7:0], instr_word[dmx_pkg::ACCESS_BIT],
                               ext_set_en, bank_sel_q, ptr2_q);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_q          <= dmx_pkg::OP_NONE;
            pend_q        <= dmx_pkg::PEND_NONE;
            second_word_q <= 1'b0;
            lit_q         <= dmx_pkg::RST_BYTE;
            sel_q         <= 2'h0;
            dst_f_q       <= 1'b0;
        end else if (at_decode) begin
            op_q          <= op_d;
            pend_q        <= pend_d;
            second_word_q <= (pend_d != dmx_pkg::PEND_NONE);
            lit_q         <= lit_d;
            sel_q         <= sel_d;
            dst_f_q       <= dst_f_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory port

    // Memory answers the cycle after the read strobe, in the process phase
    assign rd_val = is_acc(dmem_addr_q) ? acc_q : dmem_rdata;
    assign to_acc = is_acc(dmem_addr_q) || (op_q == dmx_pkg::OP_FMOVE && !dst_f_q);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dmem_addr_q <= dmx_pkg::RST_ADDR;
        end else if (at_decode) begin
            dmem_addr_q <= addr_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dmem_rd_q <= 1'b0;
        end else if (at_decode) begin
            dmem_rd_q <= (op_d == dmx_pkg::OP_FMOVE || op_d == dmx_pkg::OP_MM_SRC)
                         && !is_acc(addr_d);
        end else begin
            dmem_rd_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dmem_wr_q    <= 1'b0;
            dmem_wdata_q <= dmx_pkg::RST_BYTE;
        end else if (at_proc) begin
            dmem_wr_q <= !to_acc && (op_q == dmx_pkg::OP_STORE ||
                         op_q == dmx_pkg::OP_MM_DST || op_q == dmx_pkg::OP_FMOVE);
            if (op_q == dmx_pkg::OP_STORE) begin
                dmem_wdata_q <= acc_q;
            end else if (op_q == dmx_pkg::OP_MM_DST) begin
                dmem_wdata_q <= mm_q;
            end else begin
                dmem_wdata_q <= rd_val;
            end
        end else begin
            dmem_wr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Execution of working register, flags and move buffer

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q    <= dmx_pkg::RST_BYTE;
            flag_n_q <= 1'b0;
            flag_z_q <= 1'b0;
            mm_q     <= dmx_pkg::RST_BYTE;
        end else if (at_proc) begin
            case (op_q)
                dmx_pkg::OP_FMOVE: begin
                    flag_n_q <= rd_val[7];
                    flag_z_q <= (rd_val == 8'h00);
                    if (to_acc) begin
                        acc_q <= rd_val;
                    end
                end
                dmx_pkg::OP_MM_SRC: begin
                    mm_q <= rd_val;
                end
                dmx_pkg::OP_MM_DST: begin
                    if (to_acc) begin
                        acc_q <= mm_q;
                    end
                end
                dmx_pkg::OP_LIT: begin
                    acc_q <= lit_q;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bank select and indirect pointers

    logic [11:0] ptr_q [3];

    assign ptr0_q = ptr_q[0];
    assign ptr1_q = ptr_q[1];
    assign ptr2_q = ptr_q[dmx_pkg::IDX_PTR];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bank_sel_q <= dmx_pkg::RST_BYTE;
        end else if (at_proc && op_q == dmx_pkg::OP_BANK) begin
            bank_sel_q <= lit_q & dmx_pkg::BANK_MASK;
        end
    end

    // Select code 3 names no pointer; both words run but nothing is written
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_q[0] <= dmx_pkg::RST_PTR;
            ptr_q[1] <= dmx_pkg::RST_PTR;
            ptr_q[2] <= dmx_pkg::RST_PTR;
        end else if (at_proc && sel_q != dmx_pkg::PTR_COUNT) begin
            if (op_q == dmx_pkg::OP_PTR_HI) begin
                ptr_q[sel_q][11:8] <= lit_q[3:0];
            end else if (op_q == dmx_pkg::OP_PTR_LO) begin
                ptr_q[sel_q][7:0] <= lit_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence two_word_s;
        at_decode && (op_d == dmx_pkg::OP_PTR_HI || op_d == dmx_pkg::OP_MM_SRC);
    endsequence

    sequence lit_dec_s;
        at_decode && op_d == dmx_pkg::OP_LIT;
    endsequence

    phase_order_a: assert property (at_decode |=> phase_q == dmx_pkg::PH_READ ##1 at_proc)
        else $error("phase order broken");

    two_word_a: assert property (two_word_s |=> second_word_q [*4] ##1 !second_word_q)
        else $error("second word window wrong");

    lit_load_a: assert property (lit_dec_s |-> ##3 acc_q == $past(instr_word[7:0], 3))
        else $error("literal not in working register");

    bank_upper_a: assert property (bank_sel_q[7:4] == 4'h0)
        else $error("bank select upper nibble set");

    store_write_a: assert property (at_decode && op_d == dmx_pkg::OP_STORE
        && !is_acc(addr_d) |-> ##3 dmem_wr_q && dmem_wdata_q == acc_q)
        else $error("store did not write working register");

    flags_kept_a: assert property (at_proc && op_q != dmx_pkg::OP_FMOVE
        |=> $stable(flag_n_q) && $stable(flag_z_q))
        else $error("flags changed by non-flag move");

    fmove_acc_a: assert property (at_proc && op_q == dmx_pkg::OP_FMOVE && to_acc
        |=> acc_q == $past(rd_val) && flag_z_q == (acc_q == 8'h00) && flag_n_q == acc_q[7])
        else $error("file move result wrong");

    banked_addr_a: assert property (at_decode && op_d == dmx_pkg::OP_FMOVE
        && instr_word[8] |=> dmem_addr_q == {$past(bank_sel_q[3:0]), $past(instr_word[7:0])})
        else $error("banked address wrong");

    idx_addr_a: assert property (at_decode && op_d == dmx_pkg::OP_STORE && ext_set_en
        && !instr_word[8] && instr_word[7:0] <= dmx_pkg::IDX_LIMIT
        |=> dmem_addr_q == $past(ptr2_q) + {4'h0, $past(instr_word[7:0])})
        else $error("indexed address wrong");

    mm_read_a: assert property (at_decode && op_d == dmx_pkg::OP_MM_SRC && !is_acc(addr_d)
        |=> dmem_rd_q && dmem_addr_q == $past(instr_word[11:0]) ##1 !dmem_rd_q)
        else $error("move source read wrong");

    ptr_hi_a: assert property (at_decode && op_d == dmx_pkg::OP_PTR_HI
        && instr_word[5:4] == 2'h2 |-> ##3 ptr2_q[11:8] == $past(instr_word[3:0], 3))
        else $error("pointer high byte wrong");

endmodule

/* File: bench/dmx_mem_model.sv */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module dmx_mem_model (
    input  wire logic        clk,
    input  wire logic [11:0] addr,
    input  wire logic        rd,
    input  wire logic        wr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    // Whole 000h..FFFh space backed, no holes
    logic [7:0] mem [4096];

    initial rdata = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Plain always so the bench may preload bytes
    always @(posedge clk) begin
        if (wr) begin
            mem[addr] <= wdata;
        end
        // Byte valid only in the cycle after a strobe; toggles otherwise, so stale data fails
        if (rd) begin
            rdata <= mem[addr];
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/10ps

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

////////////////////////////////////////////////////////////////////////////////
module tb_top;
    logic                clk;
    logic                arst_n;
    logic                instr_valid;
    logic [15:0]         instr_word;
    logic                ext_set_en;
    logic [7:0]          dmem_rdata;
    dmx_pkg::dmx_phase_t phase_q;
    logic                second_word_q;
    logic [7:0]          acc_q;
    logic [7:0]          bank_sel_q;
    logic [11:0]         ptr_a [3];
    logic                flag_n_q;
    logic                flag_z_q;
    logic [11:0]         dmem_addr_q;
    logic                dmem_rd_q;
    logic                dmem_wr_q;
    logic [7:0]          dmem_wdata_q;
    int                  num_errors;
    int                  samples_checked;
    logic [11:0]         k;
    logic [15:0]         st_w [5];
    logic [11:0]         st_a [5];

    dmx_exec u_dut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .ext_set_en(ext_set_en), .dmem_rdata(dmem_rdata),
        .phase_q(phase_q), .second_word_q(second_word_q), .acc_q(acc_q),
        .bank_sel_q(bank_sel_q),
        .ptr0_q(ptr_a[0]), .ptr1_q(ptr_a[1]), .ptr2_q(ptr_a[2]), .flag_n_q(flag_n_q),
        .flag_z_q(flag_z_q), .dmem_addr_q(dmem_addr_q), .dmem_rd_q(dmem_rd_q),
        .dmem_wr_q(dmem_wr_q), .dmem_wdata_q(dmem_wdata_q));

    dmx_mem_model u_mem (.clk(clk), .addr(dmem_addr_q), .rd(dmem_rd_q), .wr(dmem_wr_q),
        .wdata(dmem_wdata_q), .rdata(dmem_rdata));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Present a word for the next decode cycle; checks after it see prior results
    task automatic step(input logic [15:0] w);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (phase_q !== dmx_pkg::PH_WRITE && n < 8);
        instr_word  <= w;
        instr_valid <= 1'b1;
    endtask

    // One word, then a no-op so its results are settled
    task automatic run(input logic [15:0] w);
        step(w);
        step(16'h0000);
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors      = 0;
        samples_checked = 0;
        arst_n          = 1'b0;
        instr_valid     = 1'b0;
        instr_word      = 16'h0000;
        ext_set_en      = 1'b0;
        st_w = '{16'h6F33, 16'h6E20, 16'h6E80, 16'h6E10, 16'h6E60};
        st_a = '{12'h533, 12'h020, 12'hF80, 12'h5DD, 12'hF60};
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        `CHK(acc_q, 8'h00)
        `CHK(phase_q, dmx_pkg::PH_DECODE)
        // Each pointer: high nibble lands one cycle before the low byte
        for (int i = 0; i < 3; i++) begin
            k = 12'(12'h3AB + 12'h111 * i);
            step({8'hEE, 2'b00, i[1:0], k[11:8]});
            step({8'hF0, k[7:0]});
            `CHK(second_word_q, 1'b1)
            `CHK(ptr_a[i], {k[11:8], 8'h00})
            step(16'h0000);
            `CHK(ptr_a[i], k)
        end
        step(16'hEE3F);
        step(16'hF0FF);
        step(16'h0000);
        `CHK(ptr_a[2], 12'h5CD)
        run(16'h01A5);
        `CHK(bank_sel_q, 8'h05)
        u_mem.mem[12'h524] = 8'h00;
        run(16'h5324);
        `CHK({flag_n_q, flag_z_q, acc_q}, 10'h100)
        // Write-back strobe is live in this cycle; the byte itself lands at this same edge
        `CHK({phase_q, dmem_rd_q, dmem_wr_q, dmem_addr_q, dmem_wdata_q}, {dmx_pkg::PH_WRITE, 1'b0, 1'b1, 12'h524, 8'h00})
        u_mem.mem[12'h523] = 8'h80;
        run(16'h5123);
        `CHK({flag_n_q, flag_z_q, acc_q}, 10'h280)
        run(16'h0E00);
        `CHK({flag_n_q, flag_z_q, acc_q}, 10'h200)
        run(16'h0E5A);
        // Banked, access low page, access high page, indexed, indexed above limit
        for (int i = 0; i < 5; i++) begin
            ext_set_en <= (i > 2);
            u_mem.mem[st_a[i]] = 8'hFF;
            run(st_w[i]);
            // Memory takes the byte at the edge run returns on
            @(negedge clk);
            `CHK(u_mem.mem[st_a[i]], 8'h5A)
        end
        `CHK({flag_n_q, flag_z_q}, 2'b10)
        // Move source and target are the 000h and FFFh end bytes
        u_mem.mem[12'h000] = 8'h3C;
        u_mem.mem[12'hFFF] = 8'h00;
        step(16'hC000);
        step(16'hFFFF);
        step(16'h0000);
        @(negedge clk);
        `CHK(u_mem.mem[12'hFFF], 8'h3C)
        `CHK({flag_n_q, flag_z_q}, 2'b10)
        step(16'hCFE8);
        step(16'hF200);
        step(16'h0000);
        @(negedge clk);
        `CHK(u_mem.mem[12'h200], 8'h5A)
        u_mem.mem[12'h123] = 8'hC3;
        u_mem.mem[12'hFE8] = 8'hEE;
        step(16'hC123);
        step(16'hFFE8);
        step(16'h0000);
        `CHK(acc_q, 8'hC3)
        `CHK(u_mem.mem[12'hFE8], 8'hEE)
        // Malformed second word is swallowed, not run as a literal load
        step(16'hC000);
        step(16'h0E77);
        step(16'h0000);
        `CHK(acc_q, 8'hC3)
        finish_test();
    end
endmodule
